// *** include/pmc_defs.svh ***
// Command codes, field positions, reset values and ranges of the power module command set
// Overview of operation
// RULE1: Run bit 7 zero disables, one enables output
// RULE2: Five config bits, default one, bit 3 writable
// RULE3: Bus enable bit clear ignores run bit
// RULE4: Pin gated powerup needs pin and command
// RULE5: Pin required bit blocks start without pin
// RULE6: Input thresholds 32 V to 46 V, 1/8 V
// RULE7: Host keeps turn-on two volts above turn-off
// RULE8: Input thresholds linear, exponent minus three
// RULE9: Store command saves thresholds, times, setpoints, margins; code only pulses nvm_store, no margin level is an output
// RULE10: Start delay 10 ms to 500 ms
// RULE11: Start ramp 15 ms to 500 ms
// RULE12: Time words linear, exponent minus one
// RULE13: Setpoint unsigned mantissa, exponent minus twelve
// RULE14: Setpoint limited to 8.10 V .. 13.20 V
// RULE15: Margin levels unsigned, exponent minus twelve
// RULE16: Run bits 5:2 select margin off/low/high
// RULE17: Output reading unsigned, exponent minus twelve
// RULE18: Output reading adds signed factory offset
// RULE19: Input reading linear, exponent minus three
// RULE20: Input trims readable, offset and gain
// RULE21: Input reading is raw times gain/8192 plus offset
// RULE22: Only store command copies to non-volatile memory
// RULE23: Two-byte words travel low byte first
// RULE24: Ignore read-only bits, keep value when out of range
// RULE25: Enable request combines pin, run bit, config
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Command codes on the link
`define PMC_CODE_RUN_CTL 8'h01
`define PMC_CODE_START_CFG 8'h02
`define PMC_CODE_STORE_ALL 8'h11
`define PMC_CODE_OUT_MODE 8'h20
`define PMC_CODE_OUT_SETPT 8'h21
`define PMC_CODE_MRG_HI 8'h25
`define PMC_CODE_MRG_LO 8'h26
`define PMC_CODE_IN_ON_THR 8'h35
`define PMC_CODE_IN_OFF_THR 8'h36
`define PMC_CODE_START_DLY 8'h60
`define PMC_CODE_START_RAMP 8'h61
`define PMC_CODE_IN_READ 8'h88
`define PMC_CODE_OUT_READ 8'h8B
`define PMC_CODE_OUT_OFS_TRIM 8'hD4
`define PMC_CODE_IN_OFS_TRIM 8'hD5
`define PMC_CODE_IN_GAIN_TRIM 8'hD6

// Field positions and fixed values
`define PMC_RUN_ON_BIT 7
`define PMC_MRG_MSB 5
`define PMC_MRG_LSB 2
`define PMC_MRG_LOW_PAT 4'h6
`define PMC_MRG_HIGH_PAT 4'hA
`define PMC_CFG_BUSEN_BIT 3
`define PMC_CFG_FIXED 8'h17
`define PMC_CFG_SENSE_LEVEL 1'h1
`define PMC_EXP_IN 5'h1D
`define PMC_EXP_TIME 5'h1F
`define PMC_OUT_MODE_VAL 8'h14
`define PMC_GAIN_SHIFT 13

// Accepted mantissa ranges
`define PMC_IN_THR_MIN 11'h100
`define PMC_IN_THR_MAX 11'h170
`define PMC_DLY_MIN 11'h014
`define PMC_RAMP_MIN 11'h01E
`define PMC_TIME_MAX 11'h3E8
`define PMC_OUT_MIN 16'h819A
`define PMC_OUT_MAX 16'hD333
`define PMC_IN_READ_MAX 16'h03FF

// Reset values of the working settings
`define PMC_RUN_RST 8'h80
`define PMC_BUSEN_RST 1'h1
`define PMC_IN_ON_RST 11'h110
`define PMC_IN_OFF_RST 11'h100
`define PMC_DLY_RST 11'h014
`define PMC_RAMP_RST 11'h01E
`define PMC_SETPT_RST 16'hC000
`define PMC_MRG_HI_RST 16'hC99A
`define PMC_MRG_LO_RST 16'hB666

// Link bit counts within a frame
`define PMC_LNK_CODE_END 6'h08
`define PMC_LNK_LO_END 6'h10
`define PMC_LNK_HI_END 6'h18
`define PMC_LNK_RD_END 6'h20
`define PMC_LNK_CNT_MAX 6'h3F

`endif

// *** include/pmc_pkg.sv ***
// Types shared by the power module command register set
package pmc_pkg;
    typedef enum logic [1:0] {
        PMC_MRG_NONE = 2'b00,
        PMC_MRG_LOW = 2'b01,
        PMC_MRG_HIGH = 2'b10
    } pmc_margin_t;
    typedef enum logic [1:0] {
        PMC_LEN_NONE = 2'b00,
        PMC_LEN_BYTE = 2'b01,
        PMC_LEN_WORD = 2'b10
    } pmc_len_t;
endpackage

// *** verilog/pmc_sync2.sv ***
// Two-stage synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none
module pmc_sync2
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage is read only by the second
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule
`default_nettype wire

// *** verilog/pmc_onoff_setpoint_regs.sv ***
// On/off control, setpoint and readback command registers behind a serial link
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"
module pmc_onoff_setpoint_regs
    import pmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_link,
    input wire logic link_frame,
    input wire logic link_data_in,
    output logic link_data_out,
    output logic link_data_oe,
    input wire logic on_off_pin,
    input wire logic [15:0] adc_vout_raw,
    input wire logic [10:0] adc_vin_raw,
    input wire logic [15:0] trim_vout_offset,
    input wire logic [15:0] trim_vin_offset,
    input wire logic [15:0] trim_vin_gain,
    output logic output_enable,
    output logic [1:0] margin_state,
    output logic [15:0] vout_target,
    output logic [10:0] vin_on_level,
    output logic [10:0] vin_off_level,
    output logic [10:0] start_delay,
    output logic [10:0] start_ramp,
    output logic nvm_store
);
    // Data length that follows each command code on a write
    function automatic pmc_len_t code_len(input logic [7:0] c);
        case (c)
            `PMC_CODE_STORE_ALL: code_len = PMC_LEN_NONE;
            `PMC_CODE_RUN_CTL,
            `PMC_CODE_START_CFG: code_len = PMC_LEN_BYTE;
            default: code_len = PMC_LEN_WORD;
        endcase
    endfunction

    // Linear word check: fixed exponent and mantissa range
    function automatic logic lin_ok(input logic [15:0] w, input logic [4:0] e,
                                    input logic [10:0] lo, input logic [10:0] hi);
        lin_ok = (w[15:11] == e) && (w[10:0] >= lo) && (w[10:0] <= hi);
    endfunction

    // Output level check against the setpoint limits
    function automatic logic out_ok(input logic [15:0] w);
        out_ok = (w >= `PMC_OUT_MIN) && (w <= `PMC_OUT_MAX);
    endfunction

    // Link domain: frame logic is cleared by the frame itself
    logic link_rst_b;
    logic [5:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] byte_now;
    logic rd_q;
    logic [7:0] code_q;
    logic [7:0] lo_q;
    logic done_q;
    logic write_commit;
    logic read_req;
    logic req_fire;
    logic req_tgl_q;
    logic wr_rd_q;
    logic [7:0] wr_code_q;
    logic [15:0] wr_word_q;
    logic [15:0] out_sr_q;
    logic [15:0] rd_src;
    logic dout_q;
    logic doe_q;
    logic ack_s;

    // Sys domain
    logic pin_s;
    logic req_s;
    logic req_seen_q;
    logic ev;
    logic wr_ev;
    logic ack_tgl_q;
    logic [15:0] rd_word_q;
    logic [15:0] rd_mux;
    logic [7:0] run_q;
    logic busen_q;
    logic [7:0] cfg_rd;
    logic [10:0] in_on_q;
    logic [10:0] in_off_q;
    logic [10:0] dly_q;
    logic [10:0] ramp_q;
    logic [15:0] setpt_q;
    logic [15:0] mrg_hi_q;
    logic [15:0] mrg_lo_q;
    logic pin_ok;
    logic en_d;
    logic out_en_q;
    pmc_margin_t margin_d;
    pmc_margin_t margin_q;
    logic [15:0] vout_tgt_q;
    logic nvm_store_q;
    logic [26:0] vin_prod;
    logic [16:0] vin_sum;
    logic [17:0] vout_sum;
    logic [15:0] vin_read_q;
    logic [15:0] vout_read_q;

    // Clock stops between frames, so frame end is the reset
    assign link_rst_b = rst_b & link_frame;
    assign byte_now = {shift_q[6:0], link_data_in};

    // Commit a write once its last byte is in
    assign write_commit = !done_q && !rd_q && (
        ((bit_cnt_q == `PMC_LNK_CODE_END) && (code_len(byte_now) == PMC_LEN_NONE)) ||
        ((bit_cnt_q == `PMC_LNK_LO_END) && (code_len(code_q) == PMC_LEN_BYTE)) ||
        ((bit_cnt_q == `PMC_LNK_HI_END) && (code_len(code_q) == PMC_LEN_WORD)));
    assign read_req = !done_q && rd_q && (bit_cnt_q == `PMC_LNK_CODE_END);
    assign req_fire = write_commit | read_req;

    // Bit counter and byte assembly, MSB first within a byte
    always_ff @(posedge clk_link or negedge link_rst_b)
    begin
        if (!link_rst_b)
        begin
            bit_cnt_q <= 6'h00;
            shift_q <= 8'h00;
            rd_q <= 1'b0;
            code_q <= 8'h00;
            lo_q <= 8'h00;
            done_q <= 1'b0;
        end
        else
        begin
            shift_q <= byte_now;
            if (bit_cnt_q != `PMC_LNK_CNT_MAX)
                bit_cnt_q <= bit_cnt_q + 6'h01;
            if (bit_cnt_q == 6'h00)
                rd_q <= link_data_in;
            if (bit_cnt_q == `PMC_LNK_CODE_END)
                code_q <= byte_now;
            if (bit_cnt_q == `PMC_LNK_LO_END)
                lo_q <= byte_now; // RULE23
            if (req_fire)
                done_q <= 1'b1;
        end
    end

    // Request words outlive the frame; sys reads them after the toggle
    always_ff @(posedge clk_link or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_tgl_q <= 1'b0;
            wr_rd_q <= 1'b0;
            wr_code_q <= 8'h00;
            wr_word_q <= 16'h0000;
        end
        else if (req_fire)
        begin
            req_tgl_q <= ~req_tgl_q;
            wr_rd_q <= rd_q;
            if (bit_cnt_q == `PMC_LNK_CODE_END)
                wr_code_q <= byte_now;
            else
                wr_code_q <= code_q;
            if (bit_cnt_q == `PMC_LNK_HI_END)
                wr_word_q <= {byte_now, lo_q}; // RULE23
            else if (bit_cnt_q == `PMC_LNK_LO_END)
                wr_word_q <= {8'h00, byte_now};
            else
                wr_word_q <= 16'h0000;
        end
    end

    // Answer is stale-safe: all ones if sys has not answered yet
    assign rd_src = (ack_s == req_tgl_q) ? rd_word_q : 16'hFFFF;

    // Read data out, low byte first, over 16 link clocks
    always_ff @(posedge clk_link or negedge link_rst_b)
    begin
        if (!link_rst_b)
        begin
            dout_q <= 1'b0;
            doe_q <= 1'b0;
            out_sr_q <= 16'h0000;
        end
        else if (rd_q && (bit_cnt_q == `PMC_LNK_LO_END))
        begin
            doe_q <= 1'b1;
            dout_q <= rd_src[7];
            out_sr_q <= {rd_src[6:0], rd_src[15:8], 1'b0}; // RULE23
        end
        else if (doe_q && (bit_cnt_q == `PMC_LNK_RD_END))
        begin
            doe_q <= 1'b0;
            dout_q <= 1'b0;
        end
        else if (doe_q)
        begin
            dout_q <= out_sr_q[15];
            out_sr_q <= {out_sr_q[14:0], 1'b0};
        end
    end

    // Crossings: answer toggle to link, request toggle and pin to sys
    pmc_sync2 #(.W(1)) u_ack_sync (
        .clk(clk_link),
        .rst_b(rst_b),
        .d(ack_tgl_q),
        .q(ack_s)
    );
    pmc_sync2 #(.W(1)) u_req_sync (
        .clk(clk_sys),
        .rst_b(rst_b),
        .d(req_tgl_q),
        .q(req_s)
    );
    pmc_sync2 #(.W(1)) u_pin_sync (
        .clk(clk_sys),
        .rst_b(rst_b),
        .d(on_off_pin),
        .q(pin_s)
    );

    assign ev = req_s != req_seen_q;
    assign wr_ev = ev && !wr_rd_q;

    // Working settings; bad values and read-only codes are dropped
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            run_q <= `PMC_RUN_RST;
            busen_q <= `PMC_BUSEN_RST; // RULE2
            in_on_q <= `PMC_IN_ON_RST;
            in_off_q <= `PMC_IN_OFF_RST;
            dly_q <= `PMC_DLY_RST;
            ramp_q <= `PMC_RAMP_RST;
            setpt_q <= `PMC_SETPT_RST;
            mrg_hi_q <= `PMC_MRG_HI_RST;
            mrg_lo_q <= `PMC_MRG_LO_RST;
        end
        else if (wr_ev)
        begin
            case (wr_code_q)
                `PMC_CODE_RUN_CTL: run_q <= wr_word_q[7:0]; // RULE1
                `PMC_CODE_START_CFG: busen_q <= wr_word_q[`PMC_CFG_BUSEN_BIT]; // RULE24
                `PMC_CODE_IN_ON_THR:
                    if (lin_ok(wr_word_q, `PMC_EXP_IN, `PMC_IN_THR_MIN, `PMC_IN_THR_MAX)) // RULE8
                        in_on_q <= wr_word_q[10:0]; // RULE6
                `PMC_CODE_IN_OFF_THR:
                    if (lin_ok(wr_word_q, `PMC_EXP_IN, `PMC_IN_THR_MIN, `PMC_IN_THR_MAX))
                        in_off_q <= wr_word_q[10:0];
                `PMC_CODE_START_DLY:
                    if (lin_ok(wr_word_q, `PMC_EXP_TIME, `PMC_DLY_MIN, `PMC_TIME_MAX)) // RULE12
                        dly_q <= wr_word_q[10:0]; // RULE10
                `PMC_CODE_START_RAMP:
                    if (lin_ok(wr_word_q, `PMC_EXP_TIME, `PMC_RAMP_MIN, `PMC_TIME_MAX))
                        ramp_q <= wr_word_q[10:0]; // RULE11
                `PMC_CODE_OUT_SETPT:
                    if (out_ok(wr_word_q))
                        setpt_q <= wr_word_q; // RULE14
                `PMC_CODE_MRG_HI:
                    if (out_ok(wr_word_q))
                        mrg_hi_q <= wr_word_q; // RULE15
                `PMC_CODE_MRG_LO:
                    if (out_ok(wr_word_q))
                        mrg_lo_q <= wr_word_q;
                default: ;
            endcase
        end
    end

    // Store pulse only; the memory writer copies the outputs
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            nvm_store_q <= 1'b0;
        else
            nvm_store_q <= wr_ev && (wr_code_q == `PMC_CODE_STORE_ALL); // RULE22
    end

    // Config byte reads back fixed ones plus the bus enable bit
    assign cfg_rd = `PMC_CFG_FIXED | ({7'h00, busen_q} << `PMC_CFG_BUSEN_BIT);

    // Read mux; unknown codes answer zero
    always_comb
    begin
        rd_mux = 16'h0000;
        case (wr_code_q)
            `PMC_CODE_RUN_CTL: rd_mux = {8'h00, run_q};
            `PMC_CODE_START_CFG: rd_mux = {8'h00, cfg_rd};
            `PMC_CODE_OUT_MODE: rd_mux = {8'h00, `PMC_OUT_MODE_VAL}; // RULE13
            `PMC_CODE_OUT_SETPT: rd_mux = setpt_q;
            `PMC_CODE_MRG_HI: rd_mux = mrg_hi_q;
            `PMC_CODE_MRG_LO: rd_mux = mrg_lo_q;
            `PMC_CODE_IN_ON_THR: rd_mux = {`PMC_EXP_IN, in_on_q};
            `PMC_CODE_IN_OFF_THR: rd_mux = {`PMC_EXP_IN, in_off_q};
            `PMC_CODE_START_DLY: rd_mux = {`PMC_EXP_TIME, dly_q};
            `PMC_CODE_START_RAMP: rd_mux = {`PMC_EXP_TIME, ramp_q};
            `PMC_CODE_OUT_READ: rd_mux = vout_read_q; // RULE17
            `PMC_CODE_IN_READ: rd_mux = vin_read_q; // RULE19
            `PMC_CODE_OUT_OFS_TRIM: rd_mux = trim_vout_offset; // RULE18
            `PMC_CODE_IN_OFS_TRIM: rd_mux = trim_vin_offset; // RULE20
            `PMC_CODE_IN_GAIN_TRIM: rd_mux = trim_vin_gain;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Answer every request; read data held until the next read
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            rd_word_q <= 16'h0000;
        end
        else if (ev)
        begin
            req_seen_q <= req_s;
            ack_tgl_q <= req_s;
            if (wr_rd_q)
                rd_word_q <= rd_mux;
        end
    end

    // Enable request, recomputed every cycle from pin, run bit, config
    assign pin_ok = pin_s == `PMC_CFG_SENSE_LEVEL;
    assign en_d = !cfg_rd[4] || // RULE4
        ((!cfg_rd[`PMC_CFG_BUSEN_BIT] || run_q[`PMC_RUN_ON_BIT]) && // RULE3
        (!cfg_rd[2] || pin_ok)); // RULE5

    // Pin-off action is always immediate; no ramp-down here
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            out_en_q <= 1'b0;
        else
            out_en_q <= en_d; // RULE25
    end

    // Margin pattern decode; other patterns fall back to nominal
    always_comb
    begin
        case (run_q[`PMC_MRG_MSB:`PMC_MRG_LSB])
            `PMC_MRG_LOW_PAT: margin_d = PMC_MRG_LOW; // RULE16
            `PMC_MRG_HIGH_PAT: margin_d = PMC_MRG_HIGH;
            default: margin_d = PMC_MRG_NONE;
        endcase
    end

    // Target level follows the margin state
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            margin_q <= PMC_MRG_NONE;
            vout_tgt_q <= `PMC_SETPT_RST;
        end
        else
        begin
            margin_q <= margin_d;
            case (margin_d)
                PMC_MRG_LOW: vout_tgt_q <= mrg_lo_q;
                PMC_MRG_HIGH: vout_tgt_q <= mrg_hi_q;
                default: vout_tgt_q <= setpt_q; // RULE13
            endcase
        end
    end

    // Corrected readings, clamped since negatives are not reportable
    assign vin_prod = {16'h0000, adc_vin_raw} * {11'h000, trim_vin_gain};
    assign vin_sum = {3'b000, vin_prod[26:`PMC_GAIN_SHIFT]} +
        {{6{trim_vin_offset[10]}}, trim_vin_offset[10:0]}; // RULE21
    assign vout_sum = {2'b00, adc_vout_raw} + {{2{trim_vout_offset[15]}}, trim_vout_offset};

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            vin_read_q <= {`PMC_EXP_IN, 11'h000};
            vout_read_q <= 16'h0000;
        end
        else
        begin
            if (vin_sum[16])
                vin_read_q <= {`PMC_EXP_IN, 11'h000};
            else if (vin_sum[15:0] > `PMC_IN_READ_MAX)
                vin_read_q <= {`PMC_EXP_IN, 1'b0, 10'(`PMC_IN_READ_MAX)};
            else
                vin_read_q <= {`PMC_EXP_IN, 1'b0, vin_sum[9:0]}; // RULE19
            if (vout_sum[17])
                vout_read_q <= 16'h0000;
            else if (vout_sum[16])
                vout_read_q <= 16'hFFFF;
            else
                vout_read_q <= vout_sum[15:0]; // RULE18
        end
    end

    assign link_data_out = dout_q;
    assign link_data_oe = doe_q;
    assign output_enable = out_en_q;
    assign margin_state = margin_q;
    assign vout_target = vout_tgt_q;
    assign vin_on_level = in_on_q; // RULE9
    assign vin_off_level = in_off_q;
    assign start_delay = dly_q;
    assign start_ramp = ramp_q;
    assign nvm_store = nvm_store_q;

    // Checks
    a_run_off_holds: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE1
        (busen_q && !run_q[`PMC_RUN_ON_BIT]) |=> !out_en_q)
        else $error("output enabled while run bit clear");
    a_cfg_write_bit: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE2
        (wr_ev && wr_code_q == `PMC_CODE_START_CFG) |=>
        (busen_q == $past(wr_word_q[3])) && (cfg_rd[2:0] == 3'h7) && cfg_rd[4])
        else $error("config write did not update bit 3 only");
    a_busen_ignore: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE3
        (!busen_q && pin_ok) |=> out_en_q)
        else $error("run bit not ignored with bus enable clear");
    a_pin_needed: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE5
        !pin_ok |=> !out_en_q)
        else $error("output enabled without pin");
    a_enable_both: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE4
        (pin_ok && run_q[`PMC_RUN_ON_BIT]) [*2] |-> out_en_q)
        else $error("pin and run bit did not enable output");
    a_in_thr_range: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE6
        (in_on_q >= `PMC_IN_THR_MIN) && (in_on_q <= `PMC_IN_THR_MAX) &&
        (in_off_q >= `PMC_IN_THR_MIN) && (in_off_q <= `PMC_IN_THR_MAX))
        else $error("input threshold out of range");
    a_time_range: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE10
        (dly_q >= `PMC_DLY_MIN) && (dly_q <= `PMC_TIME_MAX) &&
        (ramp_q >= `PMC_RAMP_MIN) && (ramp_q <= `PMC_TIME_MAX))
        else $error("start time out of range");
    a_setpt_keep: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE24
        (wr_ev && wr_code_q == `PMC_CODE_OUT_SETPT && !out_ok(wr_word_q)) |=>
        $stable(setpt_q))
        else $error("out of range setpoint accepted");
    a_margin_high: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE16
        (run_q[5:2] == 4'hA) [*2] |-> (vout_tgt_q == $past(mrg_hi_q)) &&
        (margin_q == PMC_MRG_HIGH))
        else $error("margin high not applied");
    a_store_once: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE22
        nvm_store_q |-> $past(wr_ev) && ($past(wr_code_q) == `PMC_CODE_STORE_ALL) ##1
        !nvm_store_q)
        else $error("store pulse without store command");
    a_read_length: assert property (@(posedge clk_link) disable iff (!link_rst_b) // RULE23
        $rose(doe_q) |-> doe_q [*8] ##1 doe_q [*8] ##1 !doe_q)
        else $error("read answer not sixteen bits long");
endmodule
`default_nettype wire

// *** tb/pmc_host_model.sv ***
// Host side of the serial command link: frame, link clock and shared data line
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model
(
    output logic clk_link,
    output logic link_frame,
    output logic link_data_in,
    input wire logic link_data_out,
    input wire logic link_data_oe
);
    logic drv;
    // Device wins the line while it drives; a released host shows toggling junk
    assign link_data_in = link_data_oe ? link_data_out : drv;
    initial
    begin
        clk_link = 1'b0;
        link_frame = 1'b0;
        drv = 1'b0;
    end
    // Clock only runs inside a frame; the bit is taken at the rising edge
    task automatic xfer(input logic r, input logic [7:0] c, input logic [15:0] w,
                        input int n, output logic [15:0] q);
        logic [24:0] sh;
        sh = {r, c, w[7:0], w[15:8]};
        q = 16'h0000;
        #13; // Keeps link edges off the system clock edges
        link_frame = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            drv = (r && i > 16) ? ~drv : sh[24 - i];
            #80;
            if (i > 16)
                q = {q[14:0], link_data_in};
            clk_link = 1'b1;
            #80;
            clk_link = 1'b0;
        end
        q = {q[7:0], q[15:8]};
        #80;
        link_frame = 1'b0;
        #400;
    endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the on/off, setpoint and readback command registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys, rst_b, on_off_pin, clk_link, link_frame, link_data_in;
    logic link_data_out, link_data_oe, output_enable, nvm_store;
    logic [15:0] adc_vout_raw, trim_vout_offset, trim_vin_offset, trim_vin_gain, vout_target, rd;
    logic [10:0] adc_vin_raw, vin_on_level, vin_off_level, start_delay, start_ramp;
    logic [1:0] margin_state;
    int errors, comparisons, stores;
    pmc_onoff_setpoint_regs dut_u (.clk_sys, .rst_b, .clk_link, .link_frame, .link_data_in,
        .link_data_out, .link_data_oe, .on_off_pin, .adc_vout_raw, .adc_vin_raw,
        .trim_vout_offset, .trim_vin_offset, .trim_vin_gain, .output_enable, .margin_state,
        .vout_target, .vin_on_level, .vin_off_level, .start_delay, .start_ramp, .nvm_store);
    pmc_host_model host_u (.clk_link, .link_frame, .link_data_in, .link_data_out,
        .link_data_oe);
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Counts store pulses, so a stuck or doubled pulse shows
    always @(posedge clk_sys)
        if (nvm_store === 1'b1)
            stores++;
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One frame, then time for the crossing into the system clock
    task automatic go(input logic r, input logic [7:0] c, input logic [15:0] w, input int n);
        host_u.xfer(r, c, w, n, rd);
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        chk("target", vout_target, 16'hC000);
        chk("on_thr", {5'h00, vin_on_level}, 16'h0110);
        chk("off_thr", {5'h00, vin_off_level}, 16'h0100);
        chk("delay", {5'h00, start_delay}, 16'h0014);
        chk("ramp", {5'h00, start_ramp}, 16'h001E);
        chk("enable", {15'h0000, output_enable}, 16'h0001);
        go(1'b1, 8'h02, 16'h0000, 33);
        chk("cfg", {8'h00, rd[7:0]}, 16'h001F);
        go(1'b1, 8'h20, 16'h0000, 33);
        chk("mode", rd, 16'h0014);
    endtask
    task automatic t_setpoint();
        go(1'b0, 8'h21, 16'h819A, 25);
        chk("target", vout_target, 16'h819A);
        go(1'b1, 8'h21, 16'h0000, 33);
        chk("setpt_rd", rd, 16'h819A);
        go(1'b0, 8'h21, 16'h8199, 25);
        chk("target", vout_target, 16'h819A);
        go(1'b0, 8'h21, 16'hD334, 25);
        chk("target", vout_target, 16'h819A);
    endtask
    task automatic t_margin();
        logic [7:0] run [4] = '{8'h98, 8'hA8, 8'h8C, 8'h80};
        logic [15:0] tgt [4] = '{16'hB000, 16'hC99A, 16'h819A, 16'h819A};
        logic [1:0] mrg [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
        go(1'b0, 8'h26, 16'hB000, 25);
        go(1'b0, 8'h25, 16'hD334, 25);
        for (int i = 0; i < 4; i++)
        begin
            go(1'b0, 8'h01, {8'h00, run[i]}, 17);
            chk("margin", {14'h0000, margin_state}, {14'h0000, mrg[i]});
            chk("target", vout_target, tgt[i]);
        end
    endtask
    task automatic t_onoff();
        go(1'b0, 8'h01, 16'h0000, 17);
        chk("enable", {15'h0000, output_enable}, 16'h0000);
        go(1'b0, 8'h01, 16'h0080, 17);
        chk("enable", {15'h0000, output_enable}, 16'h0001);
        go(1'b0, 8'h02, 16'h0000, 17);
        go(1'b1, 8'h02, 16'h0000, 33);
        chk("cfg", {8'h00, rd[7:0]}, 16'h0017);
        go(1'b0, 8'h01, 16'h0000, 17);
        chk("enable", {15'h0000, output_enable}, 16'h0001);
        @(posedge clk_sys) on_off_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("enable", {15'h0000, output_enable}, 16'h0000);
        @(posedge clk_sys) on_off_pin <= 1'b1;
        go(1'b0, 8'h02, 16'h0008, 17);
        chk("enable", {15'h0000, output_enable}, 16'h0000);
        go(1'b0, 8'h01, 16'h0080, 17);
        chk("enable", {15'h0000, output_enable}, 16'h0001);
    endtask
    task automatic t_limits();
        go(1'b0, 8'h35, 16'hE940, 25);
        chk("on_thr", {5'h00, vin_on_level}, 16'h0140);
        go(1'b0, 8'h35, 16'hE971, 25);
        chk("on_thr", {5'h00, vin_on_level}, 16'h0140);
        go(1'b0, 8'h36, 16'h0108, 25);
        chk("off_thr", {5'h00, vin_off_level}, 16'h0100);
        go(1'b0, 8'h60, 16'hFBE8, 25);
        chk("delay", {5'h00, start_delay}, 16'h03E8);
        go(1'b0, 8'h61, 16'hF81D, 25);
        chk("ramp", {5'h00, start_ramp}, 16'h001E);
        stores = 0;
        go(1'b0, 8'h11, 16'h0000, 9);
        chk("stores", stores[15:0], 16'h0001);
    endtask
    task automatic t_read();
        logic [7:0] c [6] = '{8'h8B, 8'h88, 8'hD4, 8'hD5, 8'hD6, 8'h99};
        logic [15:0] e [6] = '{16'h0FF0, 16'hEA08, 16'hFFF0, 16'hE808, 16'h4000, 16'h0000};
        @(posedge clk_sys);
        adc_vout_raw <= 16'h1000;
        trim_vout_offset <= 16'hFFF0;
        adc_vin_raw <= 11'h100;
        trim_vin_gain <= 16'h4000;
        trim_vin_offset <= 16'hE808;
        for (int i = 0; i < 6; i++)
        begin
            go(1'b1, c[i], 16'h0000, 33);
            chk("reading", rd, e[i]);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Reset, then the scenarios in order
    initial
    begin
        rst_b = 1'b0;
        on_off_pin = 1'b1;
        adc_vout_raw = 16'h0000;
        adc_vin_raw = 11'h000;
        trim_vout_offset = 16'h0000;
        trim_vin_offset = 16'h0000;
        trim_vin_gain = 16'h2000;
        errors = 0;
        comparisons = 0;
        stores = 0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk_sys);
        t_reset();
        t_setpoint();
        t_margin();
        t_onoff();
        t_limits();
        t_read();
        tally_and_finish();
    end
endmodule
`default_nettype wire
